// ===== src/conv_unit.sv
// Purpose: accumulator number-conversion datapath
// Assumes: sequencer answers each memory request with a one-cycle ack
// Notes: single-cycle ops finish the cycle after they are taken
`include "conv_cfg.svh"
module conv_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  conv_if.unit link
);
  import conv_pkg::*;

  unit_state_e state;
  op_e cur_op;
  logic [31:0] acc;
  logic [31:0] stack1;
  flags_s flags;
  logic done;
  logic [15:0] src_ptr;
  logic [15:0] dst_ptr;
  logic [15:0] len;
  logic [15:0] cnt;
  logic half;
  logic [7:0] pack8;
  logic [15:0] word;
  logic [15:0] wdata;

  // ----------------------------------------------------------------
  // conversion functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] tens_cpl(input logic [31:0] a);
    logic [31:0] r;
    logic b;
    logic [4:0] d;
    r = 32'h0;
    b = 1'b0;
    for (int i = 0; i < 8; i++) begin
      d = 5'h0 - {1'b0, a[4*i +: 4]} - {4'h0, b};
      b = d[4];
      if (b) begin
        d = d + 5'h0a;
      end
      r[4*i +: 4] = d[3:0];
    end
    return r; // a zero accumulator wraps back to zero
  endfunction

  function automatic logic [3:0] ascii_to_nib(input logic [7:0] c);
    logic [3:0] n;
    n = 4'h0; // invalid codes give digit zero
    if (c >= `ASCII_DIGIT_BASE && c <= `ASCII_DIGIT_BASE + 8'h09) begin
      n = 4'(c - `ASCII_DIGIT_BASE);
    end else if (c >= `ASCII_ALPHA_BASE && c <= `ASCII_ALPHA_LAST) begin
      n = 4'(c - `ASCII_ALPHA_BASE + 8'h0a);
    end
    return n;
  endfunction

  function automatic logic [7:0] nib_to_ascii(input logic [3:0] n);
    logic [7:0] c;
    c = (n < 4'ha) ? `ASCII_DIGIT_BASE + {4'h0, n}
                   : `ASCII_ALPHA_BASE + {4'h0, n} - 8'h0a;
    return c;
  endfunction

  function automatic logic [7:0] seg_of(input logic [3:0] n);
    logic [7:0] s;
    unique case (n)
      4'h0: s = 8'h3f; 4'h1: s = 8'h06; 4'h2: s = 8'h5b; 4'h3: s = 8'h4f;
      4'h4: s = 8'h66; 4'h5: s = 8'h6d; 4'h6: s = 8'h7d; 4'h7: s = 8'h07;
      4'h8: s = 8'h7f; 4'h9: s = 8'h6f; 4'ha: s = 8'h77; 4'hb: s = 8'h7c;
      4'hc: s = 8'h39; 4'hd: s = 8'h5e; 4'he: s = 8'h79; 4'hf: s = 8'h71;
    endcase
    return s; // bit 7 stays clear
  endfunction

  function automatic logic [31:0] gray_bcd(input logic [15:0] g);
    logic [15:0] bin;
    logic [19:0] bcd;
    logic [31:0] r;
    bin[15] = g[15];
    for (int i = 14; i >= 0; i--) begin
      bin[i] = bin[i+1] ^ g[i];
    end
    bcd = 20'h0;
    for (int i = 15; i >= 0; i--) begin
      for (int k = 0; k < 5; k++) begin
        if (bcd[4*k +: 4] > 4'h4) begin
          bcd[4*k +: 4] = bcd[4*k +: 4] + 4'h3;
        end
      end
      bcd = {bcd[18:0], bin[i]};
    end
    r = 32'h0;
    r[`GRAY_BCD_BITS-1:0] = bcd[`GRAY_BCD_BITS-1:0];
    return r; // upper bits cleared
  endfunction

  function automatic logic [31:0] shuffle(input logic [31:0] src,
                                          input logic [31:0] ord);
    logic [31:0] r;
    logic [3:0] o;
    r = 32'h0;
    // ascending scan so the most significant duplicate writes last
    for (int i = 0; i < `SHUFFLE_DIGITS; i++) begin
      o = ord[4*i +: 4];
      if (o >= 4'h1 && o <= 4'h8) begin
        r[4*(o-4'h1) +: 4] = src[4*i +: 4];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] int_to_float(input logic [31:0] a);
    logic [31:0] mag;
    logic [31:0] t;
    logic [4:0] p;
    logic [31:0] r;
    mag = a[31] ? 32'h0 - a : a;
    p = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        p = 5'(i);
      end
    end
    t = mag << (5'd31 - p);
    r = {a[31], `FLOAT_BIAS + {3'h0, p}, t[30:8]};
    return (mag == 32'h0) ? 32'h0 : r;
  endfunction

  // ----------------------------------------------------------------
  // float-to-int datapath
  // ----------------------------------------------------------------
  wire [7:0] f_exp = acc[30:23];
  wire [7:0] f_shift = f_exp - `FLOAT_BIAS;
  wire f_valid = f_exp != `FLOAT_EXP_MAX;
  wire f_small = f_exp < `FLOAT_BIAS;
  wire f_big = !f_small && f_shift > 8'h1e;
  wire [63:0] f_wide = {40'h0, 1'b1, acc[22:0]} << f_shift[4:0];
  wire [31:0] f_mag = (f_small || f_big || !f_valid) ? 32'h0
                                                     : f_wide[54:23];
  wire [31:0] f_res = acc[31] ? 32'h0 - f_mag : f_mag;
  wire f_sign_err = (f_mag != 32'h0) && (f_res[31] != acc[31]);
  wire [31:0] i2f_res = int_to_float(acc);

  // ----------------------------------------------------------------
  // table conversion helpers
  // ----------------------------------------------------------------
  wire [7:0] rd_nib8 = {ascii_to_nib(link.mem_rdata[15:8]),
                        ascii_to_nib(link.mem_rdata[7:0])};
  wire [15:0] cnt_next = cnt + 16'h1;
  wire op_fire = link.op_valid && state == st_idle;
  wire [15:0] oct_addr = {4'h0, link.op_data[14:12], link.op_data[10:8],
                          link.op_data[6:4], link.op_data[2:0]};

  assign link.op_ready = state == st_idle;
  assign link.op_done = done;
  assign link.acc = acc;
  assign link.stack1 = stack1;
  assign link.flags = flags;
  assign link.mem_req = state != st_idle;
  assign link.mem_we = state == st_write;
  assign link.mem_addr = (state == st_write) ? dst_ptr : src_ptr;
  assign link.mem_wdata = wdata;

  // ----------------------------------------------------------------
  // op dispatch and single-cycle ops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= st_idle;
      cur_op <= load_op;
      acc <= 32'h0;
      stack1 <= 32'h0;
      flags <= '0;
      done <= 1'b0;
      src_ptr <= 16'h0;
      dst_ptr <= 16'h0;
      len <= 16'h0;
      cnt <= 16'h0;
      half <= 1'b0;
      pack8 <= 8'h0;
      word <= 16'h0;
      wdata <= 16'h0;
    end else begin
      done <= 1'b0;
      unique case (state)
        st_idle: if (op_fire) begin
          cur_op <= link.op_code;
          done <= 1'b1;
          unique case (link.op_code)
            load_op: begin
              stack1 <= acc;
              acc <= link.op_data;
            end
            load_address_op: begin
              stack1 <= acc;
              acc <= {16'h0, oct_addr};
            end
            tens_complement_op: acc <= tens_cpl(acc);
            int_to_float_op: begin
              acc <= i2f_res;
              flags.zero_flag <= i2f_res == 32'h0;
              flags.negative_flag <= acc[31];
            end
            float_to_int_op: begin
              acc <= f_res;
              flags.zero_flag <= f_res == 32'h0;
              flags.negative_flag <= f_res[31];
              flags.valid_float_flag <= f_valid;
              flags.not_convertible_flag <= f_big || !f_valid;
              flags.sign_error_flag <= f_sign_err;
            end
            ascii_to_hex_table_op, hex_to_ascii_table_op: begin
              src_ptr <= acc[15:0];
              dst_ptr <= link.op_data[15:0];
              len <= stack1[15:0];
              cnt <= 16'h0;
              half <= 1'b0;
              if (stack1[15:0] != 16'h0) begin
                done <= 1'b0;
                state <= st_read;
              end
            end
            seven_segment_op: acc <= {seg_of(acc[15:12]), seg_of(acc[11:8]),
              seg_of(acc[7:4]), seg_of(acc[3:0])};
            gray_to_bcd_op: acc <= gray_bcd(acc[15:0]);
            digit_shuffle_op: acc <= shuffle(stack1, acc);
            default: ; // spare command codes do nothing
          endcase
        end
        // fetch one source word
        st_read: if (link.mem_ack) begin
          src_ptr <= src_ptr + 16'h1;
          cnt <= cnt_next;
          if (cur_op == hex_to_ascii_table_op) begin
            word <= link.mem_rdata;
            wdata <= {nib_to_ascii(link.mem_rdata[15:12]),
                      nib_to_ascii(link.mem_rdata[11:8])};
            half <= 1'b0;
            state <= st_write;
          end else if (half) begin
            wdata <= {pack8, rd_nib8};
            half <= 1'b0;
            state <= st_write;
          end else if (cnt_next == len) begin
            wdata <= {rd_nib8, 8'h00}; // odd last word, low byte zero
            state <= st_write;
          end else begin
            pack8 <= rd_nib8;
            half <= 1'b1;
          end
        end
        // store one destination word
        st_write: if (link.mem_ack) begin
          dst_ptr <= dst_ptr + 16'h1;
          if (cur_op == hex_to_ascii_table_op && !half) begin
            wdata <= {nib_to_ascii(word[7:4]), nib_to_ascii(word[3:0])};
            half <= 1'b1;
          end else if (cnt == len) begin
            state <= st_idle;
            done <= 1'b1;
          end else begin
            state <= st_read;
          end
        end
      endcase
    end
  end

endmodule // conv_unit

// ===== src/conv_cfg.svh
// Purpose: constants for the accumulator number-conversion unit
// Assumes: 16-bit word memory, 32-bit accumulator
// Notes: included by both ends of the link
// Behaviour
// - ten's complement: acc becomes 100000000 minus acc
// - int-to-float converts acc integer, writes acc back
// - exponent = 127 plus msb weight; rest mantissa
// - float ops set zero and negative flags
// - float-to-int converts acc float, writes acc back
// - float-to-int sets valid, not-convertible, sign-error flags
// - ascii-to-hex packs two codes per digit pair
// - program loads length, source, then gives destination
// - codes 30-39, 41-46 map to hex digits
// - hex-to-ascii doubles words, digit to code
// - digits 0-9, A-F map to codes 30-39, 41-46
// - program loads hex length, source, gives destination
// - table addresses are hex; load-address converts octal
// - every load pushes old acc to stack one
// - segment op encodes four low hex digits
// - gray op gives 10-bit BCD, clears upper bits
// - program corrects 360 or 720 count encoders
// - shuffle reorders stack digits by acc order
// - order digit 0 or 9-F yields zero digit
// - duplicate order digits: most significant one wins
// - program loads digits, then order, then shuffles
// - flags hold until an op driving them runs
`ifndef CONV_CFG_SVH
`define CONV_CFG_SVH

// ----------------------------------------------------------------
// conversion constants
// ----------------------------------------------------------------
`define FLOAT_BIAS 8'h7f
`define FLOAT_EXP_MAX 8'hff
`define ASCII_DIGIT_BASE 8'h30
`define ASCII_ALPHA_BASE 8'h41
`define ASCII_ALPHA_LAST 8'h46
`define GRAY_BCD_BITS 10
`define SHUFFLE_DIGITS 8

// ----------------------------------------------------------------
// controller register map (byte addresses)
// ----------------------------------------------------------------
`define REG_CMD 12'h000
`define REG_DATA 12'h004
`define REG_STATUS 12'h008
`define REG_ACC 12'h00c
`define REG_STACK 12'h010
`define MEM_BASE_BIT 10
`define STATUS_BUSY_BIT 5

`endif

// ===== src/conv_pkg.sv
// Purpose: shared types for the conversion unit and its sequencer
// Assumes: nothing beyond the cfg header
// Notes: op codes are listed in the order the command register uses
package conv_pkg;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    load_op,
    load_address_op,
    tens_complement_op,
    int_to_float_op,
    float_to_int_op,
    ascii_to_hex_table_op,
    hex_to_ascii_table_op,
    seven_segment_op,
    gray_to_bcd_op,
    digit_shuffle_op
  } op_e;

  typedef enum {st_idle, st_read, st_write} unit_state_e;

  typedef struct packed {
    logic not_convertible_flag;
    logic sign_error_flag;
    logic valid_float_flag;
    logic negative_flag;
    logic zero_flag;
  } flags_s;

endpackage

// ===== src/conv_if.sv
// Purpose: link between the conversion unit and its sequencer
// Assumes: one clock; sequencer owns the word memory
// Notes: op handshake is valid/ready, memory is req/ack
interface conv_if;
  import conv_pkg::*;
  logic op_valid;
  logic op_ready;
  op_e op_code;
  logic [31:0] op_data;
  logic op_done;
  logic [31:0] acc;
  logic [31:0] stack1;
  flags_s flags;
  logic mem_req;
  logic mem_we;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic mem_ack;

  modport unit (input op_valid, op_code, op_data, mem_rdata, mem_ack,
    output op_ready, op_done, acc, stack1, flags, mem_req, mem_we,
    mem_addr, mem_wdata);
  modport sequencer (output op_valid, op_code, op_data, mem_rdata,
    mem_ack, input op_ready, op_done, acc, stack1, flags, mem_req,
    mem_we, mem_addr, mem_wdata);
endinterface

// ===== src/conv_sequencer.sv
// Purpose: sequencer end: word memory and wishbone command registers
// Assumes: classic wishbone slave, 32-bit data, single cycle reads
// Notes: the unit has priority on the memory when both write at once
`include "conv_cfg.svh"
module conv_sequencer #(
  parameter int MEM_WORDS = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  conv_if.sequencer link
);
  import conv_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);

  logic [15:0] mem [MEM_WORDS];
  logic pending;
  op_e cmd;
  logic [31:0] data;
  logic [31:0] rd;
  logic ack;
  logic mack;
  logic [15:0] mrd;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = cyc_i && stb_i && !ack;
  wire wr = req && we_i;
  wire is_mem = adr_i[`MEM_BASE_BIT];
  wire [AW-1:0] bus_idx = adr_i[AW+1:2];
  wire [AW-1:0] unit_idx = link.mem_addr[AW-1:0];
  wire unit_wr = link.mem_req && link.mem_we && !mack;
  wire wr_cmd = wr && adr_i == `REG_CMD && sel_i[0];
  wire [31:0] sel_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                          {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] status = {26'h0, pending || !link.op_ready, link.flags};

  assign ack_o = ack;
  assign dat_o = rd;
  assign link.op_valid = pending;
  assign link.op_code = cmd;
  assign link.op_data = data;
  assign link.mem_ack = mack;
  assign link.mem_rdata = mrd;

  // ----------------------------------------------------------------
  // registers and command issue
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending <= 1'b0;
      cmd <= load_op;
      data <= 32'h0;
      ack <= 1'b0;
      rd <= 32'h0;
    end else begin
      ack <= req;
      if (wr_cmd) begin
        pending <= 1'b1; // a command written while busy waits here
        cmd <= op_e'(dat_i[3:0]);
      end else if (link.op_ready) begin
        pending <= 1'b0;
      end
      if (wr && adr_i == `REG_DATA) begin
        data <= (data & ~sel_mask) | (dat_i & sel_mask);
      end
      if (req && !we_i) begin
        if (is_mem) begin
          rd <= {16'h0, mem[bus_idx]};
        end else if (adr_i == `REG_DATA) begin
          rd <= data;
        end else if (adr_i == `REG_STATUS) begin
          rd <= status;
        end else if (adr_i == `REG_ACC) begin
          rd <= link.acc;
        end else if (adr_i == `REG_STACK) begin
          rd <= link.stack1;
        end else begin
          rd <= 32'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // word memory, served to the unit with a one-cycle ack
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mack <= 1'b0;
      mrd <= 16'h0;
    end else begin
      mack <= link.mem_req && !mack;
      mrd <= mem[unit_idx];
    end
  end

  always_ff @(posedge clk_i) begin
    if (unit_wr) begin
      mem[unit_idx] <= link.mem_wdata;
    end else if (wr && is_mem && sel_i[1:0] == 2'b11) begin
      mem[bus_idx] <= dat_i[15:0];
    end
  end

endmodule // conv_sequencer

// ===== bench/conv_sva.sv
// Purpose: link checker for the conversion unit and its sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: watches the link signals only; instantiated beside the link
`include "conv_cfg.svh"
module conv_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic op_done,
  input conv_pkg::op_e op_code,
  input wire logic [31:0] op_data,
  input wire logic [31:0] acc,
  input wire logic [31:0] stack1,
  input conv_pkg::flags_s flags,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import conv_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // biased exponent of the magnitude's top set bit
  function automatic logic [7:0] exp_of(input logic [31:0] v);
    logic [31:0] m;
    logic [7:0] e;
    m = v[31] ? -v : v;
    e = 8'h00;
    for (int i = 0; i < 32; i++) if (m[i]) e = 8'h7f + i[7:0];
    return e;
  endfunction

  function automatic logic code_ok(input logic [7:0] b);
    return (b >= 8'h30 && b <= 8'h39) || (b >= 8'h41 && b <= 8'h46);
  endfunction

  // remember which op owns the memory traffic that follows
  op_e run_op;
  always_ff @(posedge clk_i) begin
    if (rst_i) run_op <= load_op;
    else if (op_valid && op_ready) run_op <= op_code;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take(op_e c);
    op_valid && op_ready && op_code == c;
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_load_push;
    s_take(load_op) |=> acc == $past(op_data) && stack1 == $past(acc);
  endproperty
  a_load_push: assert property (p_load_push)
    else $error("load did not push the old acc");

  property p_i2f_sign;
    s_take(int_to_float_op) |=> acc[31] == $past(acc[31])
      && flags.negative_flag == $past(acc[31]);
  endproperty
  a_i2f_sign: assert property (p_i2f_sign)
    else $error("int to float sign or negative flag wrong");

  property p_i2f_exp;
    s_take(int_to_float_op) ##0 (acc != 32'h0)
      |=> acc[30:23] == exp_of($past(acc));
  endproperty
  a_i2f_exp: assert property (p_i2f_exp)
    else $error("int to float exponent wrong");

  property p_zero_flag;
    (s_take(int_to_float_op) or s_take(float_to_int_op))
      |=> flags.zero_flag == (acc == 32'h0);
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero flag does not match acc");

  property p_f2i_neg;
    s_take(float_to_int_op) |=> flags.negative_flag == acc[31];
  endproperty
  a_f2i_neg: assert property (p_f2i_neg)
    else $error("float to int negative flag wrong");

  property p_gray_clear;
    s_take(gray_to_bcd_op) |=> acc[31:10] == 22'h0;
  endproperty
  a_gray_clear: assert property (p_gray_clear)
    else $error("gray result upper bits not clear");

  property p_seg_bit7;
    s_take(seven_segment_op)
      |=> !acc[31] && !acc[23] && !acc[15] && !acc[7];
  endproperty
  a_seg_bit7: assert property (p_seg_bit7)
    else $error("segment byte top bit set");

  property p_flags_hold;
    op_valid && op_ready
      && !(op_code inside {int_to_float_op, float_to_int_op})
      |=> $stable(flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags changed by an op that does not drive them");

  property p_hex_code;
    mem_req && mem_we && run_op == hex_to_ascii_table_op
      |-> code_ok(mem_wdata[15:8]) && code_ok(mem_wdata[7:0]);
  endproperty
  a_hex_code: assert property (p_hex_code)
    else $error("hex to ascii wrote a code outside the table");

  // every non-table op raises done, with ready back high, one cycle after it is taken
  property p_done;
    op_valid && op_ready
      && !(op_code inside {ascii_to_hex_table_op, hex_to_ascii_table_op})
      |=> op_done && op_ready;
  endproperty
  a_done: assert property (p_done)
    else $error("single-cycle op did not finish next cycle");
endmodule // conv_sva

// ===== bench/test_accumulator_number_conversion_unit.sv
// Purpose: self-checking bench for the conversion unit and sequencer
// Assumes: wishbone slave acks one cycle after it takes a request
// Notes: every table row op is preceded by two loads to fill acc and stack one
`include "conv_cfg.svh"
module test_accumulator_number_conversion_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import conv_pkg::*;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] d;
    op_e op;
    logic [31:0] acc;
    logic [4:0] fl;
  } row_s;

  // load a, load b, run op with data d; flags {nc,se,vf,neg,z}
  row_s rows [21] = '{
    '{32'h12345678, 32'h1, 32'h0, tens_complement_op, 32'h99999999, 5'h0},
    '{32'h0, 32'h12345678, 32'h0, tens_complement_op, 32'h87654322, 5'h0},
    '{32'h0, 32'h0, 32'h0, tens_complement_op, 32'h0, 5'h0},
    '{32'h0, 32'h6, 32'h0, int_to_float_op, 32'h40c00000, 5'h00},
    '{32'h0, 32'hfffffffe, 32'h0, int_to_float_op, 32'hc0000000, 5'h02},
    '{32'h0, 32'h0, 32'h0, int_to_float_op, 32'h0, 5'h01},
    '{32'h0, 32'h1, 32'h0, int_to_float_op, 32'h3f800000, 5'h00},
    '{32'h0, 32'h40c00000, 32'h0, float_to_int_op, 32'h6, 5'h04},
    '{32'h0, 32'hc0000000, 32'h0, float_to_int_op, 32'hfffffffe, 5'h06},
    '{32'h0, 32'h4f000000, 32'h0, float_to_int_op, 32'h0, 5'h15},
    '{32'h0, 32'h0123, 32'h0, seven_segment_op, 32'h3f065b4f, 5'h15},
    '{32'h0, 32'h45ac, 32'h0, seven_segment_op, 32'h666d7739, 5'h15},
    '{32'h0, 32'habcd0046, 32'h0, gray_to_bcd_op, 32'h123, 5'h15},
    '{32'h0, 32'h1d4, 32'h0, gray_to_bcd_op, 32'h359, 5'h15},
    '{32'h12345678, 32'h87654321, 32'h0, digit_shuffle_op, 32'h12345678,
      5'h15},
    '{32'h12345678, 32'h12345678, 32'h0, digit_shuffle_op, 32'h87654321,
      5'h15},
    '{32'h12345678, 32'hf921, 32'h0, digit_shuffle_op, 32'h78, 5'h15},
    '{32'h12345678, 32'h11, 32'h0, digit_shuffle_op, 32'h7, 5'h15},
    '{32'h0, 32'h7fffffff, 32'h0, int_to_float_op, 32'h4effffff, 5'h14},
    '{32'h4, 32'h0, 32'h10, ascii_to_hex_table_op, 32'h0, 5'h14},
    '{32'h2, 32'h10, 32'h30, hex_to_ascii_table_op, 32'h0, 5'h14}
  };
  logic [15:0] src [4] = '{16'h3132, 16'h3341, 16'h4246, 16'h3039};
  logic [7:0] m_adr [8] = '{8'h10, 8'h11, 8'h12, 8'h30, 8'h31, 8'h32,
    8'h33, 8'h34};
  logic [15:0] m_exp [8] = '{16'h123a, 16'hbf09, 16'h5555, 16'h3132,
    16'h3341, 16'h4246, 16'h3039, 16'h5555};

  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [11:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  int n_mismatch, check_count, cycles;

  conv_if link();
  conv_unit u_conv_unit (.clk_i(clk_i), .rst_i(rst_i), .link(link));
  conv_sequencer u_conv_sequencer (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .link(link));
  conv_sva u_conv_sva (.clk_i(clk_i), .rst_i(rst_i),
    .op_valid(link.op_valid), .op_ready(link.op_ready),
    .op_done(link.op_done), .op_code(link.op_code),
    .op_data(link.op_data), .acc(link.acc),
    .stack1(link.stack1), .flags(link.flags), .mem_req(link.mem_req),
    .mem_we(link.mem_we), .mem_wdata(link.mem_wdata));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // generous ceiling: the full run needs under 3000 cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // classic cycle: hold until ack is sampled, then drop for a cycle
  task automatic wb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) chk("ack", 32'h1, 32'h0);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // software must see busy clear before the next command
  task automatic issue(input op_e op, input logic [31:0] d);
    logic [31:0] s;
    int n;
    wr(`REG_DATA, d);
    wr(`REG_CMD, {28'h0, op});
    n = 0;
    s = 32'h20;
    while (s[`STATUS_BUSY_BIT] !== 1'b0 && n < 50) begin
      wb(1'b0, `REG_STATUS, 32'h0, s);
      n++;
    end
    if (n == 50) chk("busy", 32'h0, 32'h1);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 12'h000;
    sel_i = 4'hf;
    dat_i = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 12'h020, 32'h0, q);
    chk("unmapped", 32'h0, q);
    for (int i = 0; i < 4; i++) wr(12'h400 + 12'(4 * i), {16'h0, src[i]});
    wr(12'h448, 32'h5555);
    wr(12'h4d0, 32'h5555);
    $display("test setup done");
    foreach (rows[i]) begin
      issue(load_op, rows[i].a);
      issue(load_op, rows[i].b);
      issue(rows[i].op, rows[i].d);
      wb(1'b0, `REG_ACC, 32'h0, q);
      if (rows[i].op < ascii_to_hex_table_op)
        chk("acc", rows[i].acc, q);
      else if (rows[i].op > hex_to_ascii_table_op)
        chk("acc", rows[i].acc, q);
      wb(1'b0, `REG_STATUS, 32'h0, q);
      chk("flags", {27'h0, rows[i].fl}, q & 32'h1f);
    end
    $display("test conversion rows done");
    // half-size packed table, double-size ascii table, guards untouched
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 12'h400 + {2'b00, m_adr[i], 2'b00}, 32'h0, q);
      chk("mem", {16'h0, m_exp[i]}, q & 32'hffff);
    end
    $display("test tables done");
    issue(load_op, 32'hcafe0001);
    issue(load_address_op, 32'h1400);
    wb(1'b0, `REG_ACC, 32'h0, q);
    chk("octal", 32'h300, q);
    wb(1'b0, `REG_STACK, 32'h0, q);
    chk("stack", 32'hcafe0001, q);
    wb(1'b0, `REG_CMD, 32'h0, q);
    chk("cmd", 32'h0, q);
    // a 360-count encoder reads 76 high; this value needs no digit borrow
    issue(load_op, 32'h00a4);
    issue(gray_to_bcd_op, 32'h0);
    wb(1'b0, `REG_ACC, 32'h0, q);
    chk("gray360", 32'h123, q - 32'h76);
    $display("test loads done");
    give_verdict();
  end
endmodule // test_accumulator_number_conversion_unit
